// *** hdl/smrl_supply_monitor.sv ***
// Function
// RULE1 - reset low on any invalid input or supply lockout
// RULE2 - after all inputs valid, hold reset for the selected timeout
// RULE3 - capacitor timeout scales at nine milliseconds per nanofarad
// RULE4 - open timeout pin gives minimum timeout near 400 us
// RULE5 - grounded timeout pin gives fixed internal 200 ms timeout
// RULE6 - timeout pin at supply: comparator mode, no timer delay
// RULE7 - select: supply both positive, open A positive B negative, ground both negative
// RULE8 - polarity and timer set up only after supply lockout clears
// RULE9 - hold reset and defer timeout until every input is valid
// RULE10 - reset output only pulls low; pull-up is external
// RULE11 - outside party keeps timeout capacitor at or below 1 uF
// RULE12 - unused input A tied to reference, only with A positive
// RULE13 - unused input B tied to ground, only with B negative
// RULE14 - invalid input during timeout clears timer; restart from zero
// RULE15 - comparator results pass a glitch filter first
// RULE16 - hysteresis only in comparator mode, only toward valid
// RULE17 - validity, select and timeout levels synchronised before use
// RULE18 - each timeout is a cycle counter with per-mode terminal count
`timescale 1ns/1ps
`default_nettype none
module smrl_supply_monitor #(
  parameter int unsigned MIN_CYCLES = smrl_pkg::CYC_MIN_TIMEOUT,
  parameter int unsigned INT_CYCLES = smrl_pkg::CYC_INT_TIMEOUT,
  parameter int unsigned TENTH_NF_CYCLES = smrl_pkg::CYC_PER_TENTH_NF,
  parameter int unsigned FILT_CYCLES = smrl_pkg::CYC_FILTER,
  parameter int unsigned HYST_CYCLES = smrl_pkg::CYC_HYST,
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // digitised comparator and lockout levels
  input wire logic aboveA,
  input wire logic aboveB,
  input wire logic supplyLow,
  // three-state select, decoded
  input wire logic selHigh,
  input wire logic selLow,
  // timeout control pin, decoded
  input wire logic tmrHigh,
  input wire logic tmrLow,
  input wire logic tmrCapSeen,
  // AHB-Lite slave
  input wire smrl_pkg::smrl_ahb_req_t ahbReq,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // open-drain system reset
  output logic rstNOut,
  output logic rstNOe
);
  import smrl_pkg::*;

  localparam int unsigned NPIN = 8;
  localparam int unsigned FILT_W = 16;
  localparam int unsigned IDX_A = 0;
  localparam int unsigned IDX_B = 1;
  localparam int unsigned IDX_SUP = 2;
  localparam int unsigned IDX_SELH = 3;
  localparam int unsigned IDX_SELL = 4;
  localparam int unsigned IDX_TMRH = 5;
  localparam int unsigned IDX_TMRL = 6;
  localparam int unsigned IDX_CAP = 7;

  typedef struct packed {
    smrl_state_t state;
    smrl_mode_t mode;
    logic polNegA;
    logic polNegB;
    logic [CNT_W-1:0] timer;
    logic [CAP_W-1:0] capTenths;
    logic rstAssert;
    logic busPend;
    logic busWrite;
    logic [7:0] busAddr;
    logic [31:0] rdata;
  } smrl_core_t;

  smrl_core_t core_ff;
  smrl_core_t nxt_core;

  logic [NPIN-1:0] pinVec;
  logic [NPIN-1:0] invVec;
  logic [NPIN-1:0] hystVec;
  logic [NPIN-1:0] lvl;
  logic validA;
  logic validB;
  logic supplyOk;
  logic allValid;
  logic cmpMode;
  logic [CNT_W-1:0] termExt;
  logic [CNT_W-1:0] termCount;
  logic addrPhase;
  logic [31:0] statusWord;

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning
  // lockout flag enters inverted so a filter fresh out of reset reads supply bad
  assign pinVec = {tmrCapSeen, tmrLow, tmrHigh, selLow, selHigh, ~supplyLow, aboveB, aboveA};
  assign cmpMode = (core_ff.mode == MODE_CMP);

  assign invVec = {5'h00, 1'b0, core_ff.polNegB, core_ff.polNegA};
  assign hystVec = {5'h00, {3{cmpMode}}};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_pin
      // RULE17 - every pin synchronised
      smrl_pin_filter #(
        .FILT_CYCLES(FILT_CYCLES),
        .HYST_CYCLES(HYST_CYCLES),
        .CNT_W(FILT_W)
      ) u_filt (
        .clk(clk),
        .rst(rst),
        .pinIn(pinVec[gi]),
        .invert(invVec[gi]),
        .hystEn(hystVec[gi]),
        .levelOut(lvl[gi])
      );
    end
  endgenerate

  assign validA = lvl[IDX_A];
  assign validB = lvl[IDX_B];
  assign supplyOk = lvl[IDX_SUP];
  // RULE1 - combined validity
  assign allValid = validA & validB & supplyOk;

  ////////////////////////////////////////////////////////////////////////////
  // terminal counts
  // RULE3 - capacitor scaled count
  assign termExt = CNT_W'(core_ff.capTenths) * CNT_W'(TENTH_NF_CYCLES);

  // RULE18 - per-mode terminal count
  always_comb
  begin
    case (core_ff.mode)
      MODE_EXT:
      begin
        // a capacitor too small to beat the open-pin time acts as open
        termCount = (termExt < CNT_W'(MIN_CYCLES)) ? CNT_W'(MIN_CYCLES) : termExt;
      end
      // RULE4 - open pin minimum
      MODE_MIN: termCount = CNT_W'(MIN_CYCLES);
      // RULE5 - internal fixed timeout
      MODE_INT: termCount = CNT_W'(INT_CYCLES);
      default: termCount = CNT_W'(1);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign addrPhase = ahbReq.hsel && ahbReq.hready && (ahbReq.htrans == HTRANS_NONSEQ);

  assign statusWord = {
    20'h00000,
    core_ff.state,
    core_ff.mode,
    core_ff.polNegB,
    core_ff.polNegA,
    supplyOk,
    validB,
    validA,
    allValid,
    core_ff.rstAssert,
    1'b0
  };

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    nxt_core = core_ff;

    case (core_ff.state)
      ST_LOCKOUT:
      begin
        nxt_core.timer = '0;
        // RULE8 - set up after lockout
        if (supplyOk)
        begin
          // RULE7 - select decode
          if (lvl[IDX_SELH])
          begin
            nxt_core.polNegA = 1'b0;
            nxt_core.polNegB = 1'b0;
          end
          else if (lvl[IDX_SELL])
          begin
            nxt_core.polNegA = 1'b1;
            nxt_core.polNegB = 1'b1;
          end
          else
          begin
            nxt_core.polNegA = 1'b0;
            nxt_core.polNegB = 1'b1;
          end
          // RULE6 - supply tie wins
          if (lvl[IDX_TMRH])
          begin
            nxt_core.mode = MODE_CMP;
          end
          else if (lvl[IDX_TMRL])
          begin
            nxt_core.mode = MODE_INT;
          end
          else if (lvl[IDX_CAP])
          begin
            nxt_core.mode = MODE_EXT;
          end
          else
          begin
            nxt_core.mode = MODE_MIN;
          end
          nxt_core.state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        nxt_core.timer = '0;
        // RULE9 - defer until all valid
        if (allValid)
        begin
          // RULE6 - no delay in comparator mode
          nxt_core.state = cmpMode ? ST_RELEASED : ST_TIMING;
        end
      end
      ST_TIMING:
      begin
        // RULE14 - restart on invalid
        if (!allValid)
        begin
          nxt_core.timer = '0;
          nxt_core.state = ST_WAIT;
        end
        // RULE2 - timeout elapsed
        else if (core_ff.timer >= termCount - 1'b1)
        begin
          nxt_core.timer = '0;
          nxt_core.state = ST_RELEASED;
        end
        else
        begin
          nxt_core.timer = core_ff.timer + 1'b1;
        end
      end
      ST_RELEASED:
      begin
        nxt_core.timer = '0;
        if (!allValid)
        begin
          nxt_core.state = ST_WAIT;
        end
      end
      default:
      begin
        nxt_core.timer = '0;
        nxt_core.state = ST_LOCKOUT;
      end
    endcase

    // lockout overrides whatever the sequence was doing
    if (!supplyOk)
    begin
      nxt_core.timer = '0;
      nxt_core.state = ST_LOCKOUT;
    end

    // RULE1 - assert unless released
    nxt_core.rstAssert = (nxt_core.state != ST_RELEASED);

    // data phase of a write
    if (core_ff.busPend && core_ff.busWrite && core_ff.busAddr == REG_CTRL_OFS)
    begin
      nxt_core.capTenths = ahbReq.hwdata[CAP_W-1:0];
    end

    nxt_core.busPend = addrPhase;
    nxt_core.busWrite = addrPhase && ahbReq.hwrite;
    nxt_core.busAddr = addrPhase ? ahbReq.haddr[7:0] : core_ff.busAddr;

    // read data staged in the address phase, unmapped reads give zero
    nxt_core.rdata = 32'h00000000;
    if (addrPhase && !ahbReq.hwrite && ahbReq.haddr[31:8] == 24'h000000)
    begin
      case (ahbReq.haddr[7:0])
        REG_CTRL_OFS: nxt_core.rdata = {{(32 - CAP_W){1'b0}}, core_ff.capTenths};
        REG_STATUS_OFS: nxt_core.rdata = statusWord;
        REG_TIMER_OFS: nxt_core.rdata = 32'(core_ff.timer);
        REG_TERM_OFS: nxt_core.rdata = 32'(termCount);
        default: nxt_core.rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core_ff.state <= ST_LOCKOUT;
      core_ff.mode <= MODE_MIN;
      core_ff.polNegA <= 1'b0;
      core_ff.polNegB <= 1'b0;
      core_ff.timer <= '0;
      core_ff.capTenths <= CAP_TENTHS_RST;
      core_ff.rstAssert <= 1'b1;
      core_ff.busPend <= 1'b0;
      core_ff.busWrite <= 1'b0;
      core_ff.busAddr <= 8'h00;
      core_ff.rdata <= 32'h00000000;
    end
    else
    begin
      core_ff <= nxt_core;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // zero wait states keep the slave simple; every access completes at once
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = core_ff.rdata;

  // RULE10 - open drain, low only
  assign rstNOut = 1'b0;
  assign rstNOe = core_ff.rstAssert;

endmodule : smrl_supply_monitor
`default_nettype wire

// *** hdl/smrl_pkg.sv ***
`default_nettype none
package smrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and time base
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000;

  localparam int unsigned MIN_TIMEOUT_US = 400;
  localparam int unsigned INT_TIMEOUT_MS = 200;
  // external timeout: 9 ms per nF, capacitance held in tenths of a nF
  localparam int unsigned EXT_US_PER_NF = 9000;
  localparam int unsigned EXT_US_PER_TENTH_NF = EXT_US_PER_NF / 10;
  localparam int unsigned FILTER_US = 20;
  localparam int unsigned HYST_US = 10;

  localparam int unsigned CYC_MIN_TIMEOUT = MIN_TIMEOUT_US * CLK_PER_US;
  localparam int unsigned CYC_INT_TIMEOUT = INT_TIMEOUT_MS * CLK_PER_MS;
  localparam int unsigned CYC_PER_TENTH_NF = EXT_US_PER_TENTH_NF * CLK_PER_US;
  localparam int unsigned CYC_FILTER = FILTER_US * CLK_PER_US;
  localparam int unsigned CYC_HYST = HYST_US * CLK_PER_US;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_TIMER_OFS = 8'h08;
  localparam logic [7:0] REG_TERM_OFS = 8'h0C;
  localparam int unsigned CAP_W = 14;
  // 2.2 nF
  localparam logic [13:0] CAP_TENTHS_RST = 14'h0016;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ST_LOCKOUT = 2'b00,
    ST_WAIT = 2'b01,
    ST_TIMING = 2'b10,
    ST_RELEASED = 2'b11
  } smrl_state_t;

  typedef enum logic [1:0] {
    MODE_EXT = 2'b00,
    MODE_MIN = 2'b01,
    MODE_INT = 2'b10,
    MODE_CMP = 2'b11
  } smrl_mode_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } smrl_ahb_req_t;

endpackage : smrl_pkg
`default_nettype wire

// *** hdl/smrl_pin_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module smrl_pin_filter #(
  parameter int unsigned FILT_CYCLES = smrl_pkg::CYC_FILTER,
  parameter int unsigned HYST_CYCLES = smrl_pkg::CYC_HYST,
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin level and how to read it
  input wire logic pinIn,
  input wire logic invert,
  input wire logic hystEn,
  // filtered, possibly inverted level
  output logic levelOut
);
  import smrl_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [CNT_W-1:0] cnt;
  } smrl_filt_t;

  smrl_filt_t cur_ff;
  smrl_filt_t nxt_cur;

  always_comb
  begin
    logic toValid;
    logic [CNT_W-1:0] limit;
    toValid = 1'b0;
    limit = CNT_W'(FILT_CYCLES);
    nxt_cur = cur_ff;
    nxt_cur.sync = {cur_ff.sync[1:0], pinIn};
    // RULE15 - glitch filter
    if (cur_ff.sync[2] == cur_ff.sync[1] && cur_ff.sync[2] != cur_ff.level)
    begin
      toValid = cur_ff.sync[2] ^ invert;
      // RULE16 - hysteresis on rise
      if (hystEn && toValid)
      begin
        limit = CNT_W'(FILT_CYCLES + HYST_CYCLES);
      end
      if (cur_ff.cnt >= limit - 1'b1)
      begin
        nxt_cur.level = cur_ff.sync[2];
        nxt_cur.cnt = '0;
      end
      else
      begin
        nxt_cur.cnt = cur_ff.cnt + 1'b1;
      end
    end
    else
    begin
      // any disagreement or return restarts the qualifying time
      nxt_cur.cnt = '0;
    end
  end

  // RULE17 - pin synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign levelOut = cur_ff.level ^ invert;

endmodule : smrl_pin_filter
`default_nettype wire

// *** verification/smrl_reset_line.sv ***
`timescale 1ns/1ps
`default_nettype none
module smrl_reset_line (
  // open-drain driver of the block
  input wire logic rstNOut,
  input wire logic rstNOe,
  // level seen by the reset consumer
  output logic lineLevel
);
  assign lineLevel = rstNOe ? rstNOut : 1'b1;
endmodule : smrl_reset_line
`default_nettype wire

// *** verification/smrl_supply_monitor_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module smrl_supply_monitor_props #(
  parameter int unsigned MIN_CYCLES = 20,
  parameter int unsigned INT_CYCLES = 50,
  parameter int unsigned FILT_CYCLES = 4,
  parameter int unsigned HYST_CYCLES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // monitored levels and strap pins
  input wire logic aboveA,
  input wire logic aboveB,
  input wire logic supplyLow,
  input wire logic selHigh,
  input wire logic selLow,
  input wire logic tmrHigh,
  input wire logic tmrLow,
  input wire logic tmrCapSeen,
  // reset driver
  input wire logic rstNOut,
  input wire logic rstNOe
);
  logic validRaw;
  logic [15:0] validCnt_ff;
  // straps only change in lockout, so live pins match the latched polarity
  assign validRaw = !supplyLow && (aboveA ^ (selLow && !selHigh)) && (aboveB ^ !selHigh);
  always_ff @(posedge clk or posedge rst)
    if (rst)
      validCnt_ff <= '0;
    else
      validCnt_ff <= !validRaw ? '0 : (&validCnt_ff ? validCnt_ff : validCnt_ff + 16'h0001);
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence invalidRun;
    (!validRaw)[*8] ##1 (!validRaw)[*4];
  endsequence
  sequence oneDip;
    !validRaw ##1 validRaw[*8];
  endsequence
  od_pull_low_a: assert property (rstNOut == 1'b0)
    else $error("reset driver not pulling low");
  hold_in_reset_a: assert property (disable iff (1'b0) rst |-> rstNOe)
    else $error("reset released during lockout");
  invalid_asserts_a: assert property (invalidRun |-> rstNOe)
    else $error("reset not asserted on invalid input");
  glitch_reject_a: assert property ((!rstNOe && validRaw) ##1 oneDip |-> !rstNOe)
    else $error("short dip reached reset");
  release_early_a: assert property ($fell(rstNOe) |-> validCnt_ff >= FILT_CYCLES + 2)
    else $error("release before inputs qualified");
  min_window_a: assert property ($fell(rstNOe) && !tmrHigh && !tmrLow && !tmrCapSeen
    |-> validCnt_ff inside {[MIN_CYCLES + FILT_CYCLES : MIN_CYCLES + FILT_CYCLES + 14]})
    else $error("minimum timeout wrong");
  int_window_a: assert property ($fell(rstNOe) && tmrLow && !tmrHigh
    |-> validCnt_ff inside {[INT_CYCLES + FILT_CYCLES : INT_CYCLES + FILT_CYCLES + 14]})
    else $error("internal timeout wrong");
  cmp_window_a: assert property ($fell(rstNOe) && tmrHigh
    |-> validCnt_ff inside {[FILT_CYCLES + HYST_CYCLES : FILT_CYCLES + HYST_CYCLES + 14]})
    else $error("comparator mode delay wrong");
endmodule : smrl_supply_monitor_props
`default_nettype wire

// *** verification/smrl_supply_monitor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module smrl_supply_monitor_tb_top;
  import smrl_pkg::*;
  localparam int MIN_C = 20;
  localparam int INT_C = 50;
  localparam int TNF_C = 2;
  localparam int FILT_C = 4;
  localparam int HYST_C = 2;
  logic clk, rst, aboveA, aboveB, supplyLow, selHigh, selLow, tmrHigh, tmrLow, tmrCapSeen;
  logic hreadyout, hresp, rstNOut, rstNOe, lineLevel, prevLine, rdPend;
  logic [31:0] hrdata;
  logic [13:0] cap;
  smrl_ahb_req_t ahbDrv, ahbReq;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int markCyc = 0;
  int expQ[$];
  logic [31:0] rdQ[$];
  always_comb
  begin
    ahbReq = ahbDrv;
    ahbReq.hready = hreadyout;
  end
  smrl_supply_monitor #(.MIN_CYCLES(MIN_C), .INT_CYCLES(INT_C), .TENTH_NF_CYCLES(TNF_C),
    .FILT_CYCLES(FILT_C), .HYST_CYCLES(HYST_C)) dut_u (.clk(clk), .rst(rst),
    .aboveA(aboveA), .aboveB(aboveB), .supplyLow(supplyLow), .selHigh(selHigh),
    .selLow(selLow), .tmrHigh(tmrHigh), .tmrLow(tmrLow), .tmrCapSeen(tmrCapSeen),
    .ahbReq(ahbReq), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rstNOut(rstNOut), .rstNOe(rstNOe));
  smrl_reset_line line_u (.rstNOut(rstNOut), .rstNOe(rstNOe), .lineLevel(lineLevel));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic fail_msg(input string m);
    $display("[FAIL] %0t %s", $time, m);
    fail_count++;
  endtask : fail_msg
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) fail_msg("read data mismatch");
  endtask : chk_rd
  task automatic chk_delay(input int got, input int exp);
    total_checks++;
    if (got < exp || got > exp + 14) fail_msg("release delay out of window");
  endtask : chk_delay
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) fail_msg("reset line level wrong");
  endtask : chk_bit
  task automatic close_out();
    if (expQ.size() > 0 || rdQ.size() > 0) fail_msg("results missing");
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk);
    ahbDrv.hsel <= 1'b1;
    ahbDrv.htrans <= HTRANS_NONSEQ;
    ahbDrv.haddr <= {24'h000000, adr};
    ahbDrv.hwrite <= wr;
    ahbDrv.hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    ahbDrv.hsel <= 1'b0;
    ahbDrv.htrans <= 2'h0;
    ahbDrv.hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rdQ.push_back(exp);
    bus(1'b0, adr, 32'h0000_0000);
  endtask : rd
  task automatic wait_line(input logic lvl, input int lim);
    for (int n = 0; n < lim && lineLevel !== lvl; n++) @(posedge clk);
  endtask : wait_line
  // lockout with new straps, then all inputs valid at once; brk drops input A mid-timeout so the timeout restarts
  task automatic run_mode(input logic sH, sL, tH, tL, tC, input int exp, input int brk);
    logic vA;
    logic vB;
    // valid level of input A, low when the select makes it negative
    vA = !(sL && !sH);
    // valid level of input B, high only when the select makes it positive
    vB = sH;
    @(posedge clk);
    supplyLow <= 1'b1;
    {selHigh, selLow, tmrHigh, tmrLow, tmrCapSeen} <= {sH, sL, tH, tL, tC};
    aboveA <= !vA;
    aboveB <= !vB;
    repeat (16) @(posedge clk);
    supplyLow <= 1'b0;
    aboveA <= vA;
    aboveB <= vB;
    markCyc <= cyc;
    if (brk > 0)
    begin
      repeat (brk) @(posedge clk);
      aboveA <= !vA;
      repeat (10) @(posedge clk);
      aboveA <= vA;
      markCyc <= cyc;
    end
    expQ.push_back(exp);
    wait_line(1'b1, 400);
  endtask : run_mode
  ////////////////////////////////////////////////////////////////////////////
  // result watcher: oldest note against what shows up
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    prevLine <= lineLevel;
    rdPend <= ahbReq.hsel && ahbReq.htrans == HTRANS_NONSEQ && !ahbReq.hwrite && hreadyout;
    if (rdPend === 1'b1 && rdQ.size() > 0) chk_rd(hrdata, rdQ.pop_front());
    if (rdPend === 1'b1) chk_rd({31'h00000000, hresp}, {31'h00000000, HRESP_OKAY});
    if (lineLevel === 1'b1 && prevLine === 1'b0 && expQ.size() > 0)
      chk_delay(cyc - markCyc, expQ.pop_front());
    if (cyc == 3000)
    begin
      fail_msg("timeout");
      close_out();
    end
  end
  initial
  begin
    rst = 1'b1;
    {aboveA, aboveB, supplyLow, selHigh, selLow} = 5'h04;
    {tmrHigh, tmrLow, tmrCapSeen} = 3'h0;
    ahbDrv = '0;
    void'($urandom(32'hFFEF733F));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CTRL_OFS, {18'h00000, CAP_TENTHS_RST});
    rd(8'h10, 32'h0000_0000);
    // capacitor far below the 1 uF ceiling
    cap = 14'($urandom_range(40, 15));
    bus(1'b1, REG_CTRL_OFS, {18'h00000, cap});
    rd(REG_CTRL_OFS, {18'h00000, cap});
    run_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, MIN_C + FILT_C, 0);
    run_mode(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, INT_C + FILT_C, 30);
    run_mode(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, int'(cap) * TNF_C + FILT_C, 0);
    rd(REG_TERM_OFS, {18'h00000, cap} * TNF_C);
    run_mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, FILT_C + HYST_C, 0);
    @(posedge clk);
    aboveB <= 1'b1;
    @(posedge clk);
    aboveB <= 1'b0;
    repeat (15) @(posedge clk);
    chk_bit(lineLevel, 1'b1);
    aboveB <= 1'b1;
    wait_line(1'b0, 40);
    chk_bit(lineLevel, 1'b0);
    close_out();
  end
endmodule : smrl_supply_monitor_tb_top
bind smrl_supply_monitor smrl_supply_monitor_props #(.MIN_CYCLES(MIN_CYCLES),
  .INT_CYCLES(INT_CYCLES), .FILT_CYCLES(FILT_CYCLES), .HYST_CYCLES(HYST_CYCLES)) props_u (
  .clk(clk), .rst(rst), .aboveA(aboveA), .aboveB(aboveB), .supplyLow(supplyLow),
  .selHigh(selHigh), .selLow(selLow), .tmrHigh(tmrHigh), .tmrLow(tmrLow),
  .tmrCapSeen(tmrCapSeen), .rstNOut(rstNOut), .rstNOe(rstNOe));
`default_nettype wire
